// ---- hw/mpr_pin_routing.v ----
// multifunction terminal routing register and selection logic
// Function
// - bits 31 to 28 read zero, ignore writes
// - reset value 0x00001000, terminal 3 serial
// - eeprom may preload the register default
// - register at offset 0x8C, both functions
// - terminal 6: clock-run or interrupt lines 2-15
// - terminal 5 code table selection
// - terminal 4 code table selection
// - terminal 3: serial interrupt or lines 2-15
// - terminal 2 code table selection
// - terminal 1 code table selection
// - serial-bus strap puts SDA, SCL on 1, 4
`timescale 1ns/1ps
`include "mpr_consts.vh"
module mpr_pin_routing (
  input  wire        clock,
  input  wire        rstn,
  input  wire        cfg_write,
  input  wire        cfg_read,
  input  wire        cfg_func,
  input  wire [7:0]  cfg_addr,
  input  wire [3:0]  cfg_byte_en,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata,
  input  wire        eeprom_load,
  input  wire [31:0] eeprom_data,
  input  wire        serial_bus_mode_n,
  input  wire        sda_out,
  input  wire        sda_oe,
  input  wire        scl_out,
  input  wire        scl_oe,
  output reg         sda_in,
  output reg         scl_in,
  input  wire [15:0] irq_lines,
  input  wire        serial_interrupt_out,
  input  wire        clkrun_out,
  input  wire        clkrun_oe,
  output reg         clkrun_in,
  input  wire [4:0]  general_output,
  output reg  [4:0]  general_input,
  input  wire        inta_out,
  input  wire        intb_out,
  input  wire        arbitration_grant,
  output reg         arbitration_request,
  input  wire        lock_out,
  input  wire        lock_oe,
  output reg         lock_in,
  input  wire        zoom_status,
  input  wire        zoom_select_0,
  input  wire        zoom_select_1,
  input  wire        card_audio_pwm,
  input  wire        power_state_indicator,
  input  wire        socket0_activity_led,
  input  wire        socket1_activity_led,
  input  wire        socket_led,
  input  wire        general_event,
  input  wire        ring_indicate,
  input  wire [6:0]  pin_in,
  output reg  [6:0]  pin_out,
  output reg  [6:0]  pin_oe
);

  reg  [31:0] route;
  reg  [31:0] next_route;
  reg  [31:0] wmask;
  reg  [6:0]  next_out;
  reg  [6:0]  next_oe;
  reg  [4:0]  next_gpi;
  reg         next_req;
  reg         next_clkrun;
  reg         next_lock;
  reg         next_sda;
  reg         next_scl;
  wire        reg_hit;
  wire [3:0]  f0;
  wire [3:0]  f1;
  wire [3:0]  f2;
  wire [3:0]  f3;
  wire [3:0]  f4;
  wire [3:0]  f5;
  wire [3:0]  f6;

  // register decode: same offset in either function
  // cfg_func is left unread on purpose: one register serves both
  // functions, so a write through either one lands in the same flops
  // and a read through either one returns the same word
  assign reg_hit = (cfg_addr == `MPR_ROUTE_OFFSET);

  // field slices, one nibble per terminal

  assign f0 = route[`MPR_F0_LSB +: 4];
  assign f1 = route[`MPR_F1_LSB +: 4];
  assign f2 = route[`MPR_F2_LSB +: 4];
  assign f3 = route[`MPR_F3_LSB +: 4];
  assign f4 = route[`MPR_F4_LSB +: 4];
  assign f5 = route[`MPR_F5_LSB +: 4];
  assign f6 = route[`MPR_F6_LSB +: 4];

  // interrupt line picked by a code, line number equals the code
  // codes below 2 never reach this pick with the terminal driven,
  // so the low lines it may return are harmless
  function irq_pick;
    input [15:0] lines;
    input [3:0]  code;
    begin
      irq_pick = lines[code - `MPR_IRQ_BASE];
    end
  endfunction

  // source for terminals 0 and 1; only the code 1 and code 2 sources differ
  // sharing one table keeps the two terminals from drifting apart
  function low_pick;
    input [3:0]  code;
    input        gpo;
    input        intx;
    input [15:0] lines;
    input        zst;
    input        zs0;
    input        aud;
    input        led0;
    input        led1;
    input        gev;
    begin
      case (code)
        `MPR_CODE_GPO: low_pick = gpo;
        `MPR_CODE_C2:  low_pick = intx;
        `MPR_CODE_C6:  low_pick = zst;
        `MPR_CODE_C7:  low_pick = zs0;
        `MPR_CODE_C8:  low_pick = aud;
        `MPR_CODE_CC:  low_pick = led0;
        `MPR_CODE_CD:  low_pick = led1;
        `MPR_CODE_CE:  low_pick = gev;
        default:       low_pick = irq_pick(lines, code);
      endcase
    end
  endfunction

  // byte-enabled write mask; top nibble never writable
  // the preload wins over a config write in the same cycle, so a
  // stray write during the serial load cannot corrupt the default
  always @* begin
    wmask = {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}},
             {8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}} &
            `MPR_ROUTE_WMASK;
    next_route = route;
    if (eeprom_load) begin
      next_route = eeprom_data & `MPR_ROUTE_WMASK;
    end else if (cfg_write && reg_hit) begin
      next_route = (route & ~wmask) | (cfg_wdata & wmask);
    end
  end

  // terminal output select
  // every terminal is worked out from the register and the live
  // sources, then registered, so pins change one cycle after a source
  // a reprogram in operation may glitch a terminal for that cycle
  always @* begin
    next_out = `MPR_PIN_IDLE;
    next_oe  = `MPR_PIN_ALL;
    // terminal 0
    next_oe[0] = (f0 != `MPR_CODE_GPI);
    next_out[0] = low_pick(f0, general_output[0], inta_out, irq_lines,
                           zoom_status, zoom_select_0, card_audio_pwm,
                           socket0_activity_led, socket1_activity_led,
                           general_event);
    // terminal 1
    next_oe[1] = (f1 != `MPR_CODE_GPI);
    next_out[1] = low_pick(f1, general_output[1], intb_out, irq_lines,
                           zoom_status, zoom_select_0, card_audio_pwm,
                           socket0_activity_led, socket1_activity_led,
                           general_event);
    // terminal 2
    // the arbitration request comes in from the board, so code 2
    // leaves the terminal undriven like a general input
    next_oe[2] = (f2 != `MPR_CODE_GPI) && (f2 != `MPR_CODE_C2);
    case (f2)
      `MPR_CODE_GPO: next_out[2] = general_output[2];
      `MPR_CODE_C6:  next_out[2] = zoom_status;
      `MPR_CODE_C7:  next_out[2] = zoom_select_0;
      `MPR_CODE_C8:  next_out[2] = card_audio_pwm;
      `MPR_CODE_CB:  next_out[2] = power_state_indicator;
      `MPR_CODE_CC:  next_out[2] = ring_indicate;
      `MPR_CODE_CD:  next_out[2] = socket1_activity_led;
      `MPR_CODE_CE:  next_out[2] = general_event;
      `MPR_CODE_CF:  next_out[2] = irq_lines[`MPR_IRQ7];
      default:       next_out[2] = irq_pick(irq_lines, f2);
    endcase
    // terminal 3: serial interrupt or irq, code 0 reserved
    next_oe[3] = (f3 != `MPR_CODE_GPI);
    next_out[3] = (f3 == `MPR_CODE_GPO) ? serial_interrupt_out
                                        : irq_pick(irq_lines, f3);
    // terminal 4
    // the bus lock is open drain: its own enable decides when it pulls
    next_oe[4] = (f4 != `MPR_CODE_GPI) &&
                 ((f4 != `MPR_CODE_C2) || lock_oe);
    case (f4)
      `MPR_CODE_GPO: next_out[4] = general_output[3];
      `MPR_CODE_C2:  next_out[4] = lock_out;
      `MPR_CODE_C6:  next_out[4] = zoom_status;
      `MPR_CODE_C7:  next_out[4] = zoom_select_1;
      `MPR_CODE_C8:  next_out[4] = card_audio_pwm;
      `MPR_CODE_CC:  next_out[4] = ring_indicate;
      `MPR_CODE_CD:  next_out[4] = socket_led;
      `MPR_CODE_CE:  next_out[4] = general_event;
      `MPR_CODE_CF:  next_out[4] = power_state_indicator;
      default:       next_out[4] = irq_pick(irq_lines, f4);
    endcase
    // terminal 5
    next_oe[5] = (f5 != `MPR_CODE_GPI);
    case (f5)
      `MPR_CODE_GPO: next_out[5] = general_output[4];
      `MPR_CODE_C2:  next_out[5] = arbitration_grant;
      `MPR_CODE_C6:  next_out[5] = zoom_status;
      `MPR_CODE_C7:  next_out[5] = zoom_select_1;
      `MPR_CODE_C8:  next_out[5] = card_audio_pwm;
      `MPR_CODE_C9:  next_out[5] = power_state_indicator;
      `MPR_CODE_CC:  next_out[5] = socket0_activity_led;
      `MPR_CODE_CD:  next_out[5] = socket_led;
      `MPR_CODE_CE:  next_out[5] = general_event;
      default:       next_out[5] = irq_pick(irq_lines, f5);
    endcase
    // terminal 6: clock-run is open drain, code 0 reserved
    next_oe[6] = (f6 == `MPR_CODE_GPO) ? clkrun_oe
                                       : (f6 != `MPR_CODE_GPI);
    next_out[6] = (f6 == `MPR_CODE_GPO) ? clkrun_out
                                        : irq_pick(irq_lines, f6);
    // strap overrides terminals 1 and 4 with the serial bus
    // done last so it beats whatever the fields asked for; the
    // serial-bus engine owns both enables while the strap is low
    if (!serial_bus_mode_n) begin
      next_out[1] = sda_out;
      next_oe[1]  = sda_oe;
      next_out[4] = scl_out;
      next_oe[4]  = scl_oe;
    end
  end

  // terminal input capture; reserved codes read as idle
  // an input not routed to its terminal rests at its idle level, so
  // a floating or driven terminal never leaks into the wrong consumer
  // active-low inputs (lock, clock-run, serial bus) idle high
  always @* begin
    next_gpi[0] = (f0 == `MPR_CODE_GPI) & pin_in[0];
    next_gpi[1] = (f1 == `MPR_CODE_GPI) & serial_bus_mode_n & pin_in[1];
    next_gpi[2] = (f2 == `MPR_CODE_GPI) & pin_in[2];
    next_gpi[3] = (f4 == `MPR_CODE_GPI) & serial_bus_mode_n & pin_in[4];
    next_gpi[4] = (f5 == `MPR_CODE_GPI) & pin_in[5];
    next_req    = (f2 == `MPR_CODE_C2) & pin_in[2];
    next_lock   = (f4 != `MPR_CODE_C2) | ~serial_bus_mode_n | pin_in[4];
    next_clkrun = (f6 != `MPR_CODE_GPO) | pin_in[6];
    next_sda    = serial_bus_mode_n | pin_in[1];
    next_scl    = serial_bus_mode_n | pin_in[4];
  end

  // register and output flops
  // every output leaves a flop, so the pins see no decode glitches
  // reset releases all terminals; terminal 3 drives from the next edge
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      route               <= `MPR_ROUTE_RESET;
      cfg_rdata           <= `MPR_ZERO32;
      pin_out             <= `MPR_PIN_IDLE;
      pin_oe              <= `MPR_PIN_IDLE;
      general_input       <= `MPR_GPI_IDLE;
      arbitration_request <= 1'b0;
      lock_in             <= 1'b1;
      clkrun_in           <= 1'b1;
      sda_in              <= 1'b1;
      scl_in              <= 1'b1;
    end else begin
      route               <= next_route;
      // read data holds between reads; unmapped offsets read zero
      if (cfg_read && reg_hit) begin
        cfg_rdata <= route & `MPR_ROUTE_WMASK;
      end else if (cfg_read) begin
        cfg_rdata <= `MPR_ZERO32;
      end
      pin_out             <= next_out;
      pin_oe              <= next_oe;
      general_input       <= next_gpi;
      arbitration_request <= next_req;
      lock_in             <= next_lock;
      clkrun_in           <= next_clkrun;
      sda_in              <= next_sda;
      scl_in              <= next_scl;
    end
  end

endmodule // mpr_pin_routing

// ---- common/mpr_consts.vh ----
// constants for the multifunction terminal routing block
`ifndef MPR_CONSTS_VH
`define MPR_CONSTS_VH
`define MPR_ROUTE_OFFSET  8'h8C
`define MPR_ROUTE_RESET   32'h00001000
`define MPR_ROUTE_WMASK   32'h0FFFFFFF
`define MPR_ZERO32        32'h00000000
`define MPR_CODE_GPI      4'h0
`define MPR_CODE_GPO      4'h1
`define MPR_CODE_C2       4'h2
`define MPR_CODE_C3       4'h3
`define MPR_CODE_C4       4'h4
`define MPR_CODE_C5       4'h5
`define MPR_CODE_C6       4'h6
`define MPR_CODE_C7       4'h7
`define MPR_CODE_C8       4'h8
`define MPR_CODE_C9       4'h9
`define MPR_CODE_CA       4'hA
`define MPR_CODE_CB       4'hB
`define MPR_CODE_CC       4'hC
`define MPR_CODE_CD       4'hD
`define MPR_CODE_CE       4'hE
`define MPR_CODE_CF       4'hF
`define MPR_IRQ_BASE      4'h0
`define MPR_F0_LSB        0
`define MPR_F1_LSB        4
`define MPR_F2_LSB        8
`define MPR_F3_LSB        12
`define MPR_F4_LSB        16
`define MPR_F5_LSB        20
`define MPR_F6_LSB        24
`define MPR_PIN_IDLE      7'h00
`define MPR_PIN_ALL       7'h7F
`define MPR_GPI_IDLE      5'h00
`define MPR_IRQ7          4'h7
`endif

// ---- verif/mpr_board.sv ----
// board-level circuits seen at the seven terminals
`timescale 1ns/1ps
module mpr_board (
  input  wire [6:0] pin_out,
  input  wire [6:0] pin_oe,
  input  wire [6:0] noise,
  output wire [6:0] pin_in
);
  // a driven terminal reads back its level, an idle one floats as noise
  assign pin_in = (pin_out & pin_oe) | (noise & ~pin_oe);
endmodule // mpr_board

// ---- verif/mpr_pin_routing_props.sv ----
// assertion checker for the terminal routing block
`timescale 1ns/1ps
module mpr_props (
  input wire        clock,
  input wire        rstn,
  input wire        cfg_write,
  input wire        cfg_read,
  input wire [7:0]  cfg_addr,
  input wire [3:0]  cfg_byte_en,
  input wire [31:0] cfg_wdata,
  input wire [31:0] cfg_rdata,
  input wire        eeprom_load,
  input wire [31:0] eeprom_data,
  input wire        serial_bus_mode_n,
  input wire        sda_oe,
  input wire        scl_oe,
  input wire [15:0] irq_lines,
  input wire        serial_interrupt_out,
  input wire        card_audio_pwm,
  input wire        ring_indicate,
  input wire [6:0]  pin_in,
  input wire [4:0]  general_input,
  input wire [6:0]  pin_out,
  input wire [6:0]  pin_oe
);
  logic [31:0] sh, p_sh, bm;
  logic [15:0] p_irq;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // shadow copy of the routing register, upper nibble never writable
  assign bm = {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}},
               {8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}} & 32'h0FFFFFFF;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sh <= 32'h00001000;
      p_sh <= 32'h00001000;
      p_irq <= 16'h0000;
    end else begin
      p_sh <= sh;
      p_irq <= irq_lines;
      if (eeprom_load)
        sh <= eeprom_data & 32'h0FFFFFFF;
      else if (cfg_write && cfg_addr == 8'h8C)
        sh <= (sh & ~bm) | (cfg_wdata & bm);
    end
  end
  sequence s_rd;
    cfg_read && cfg_addr == 8'h8C;
  endsequence
  property p_rd;
    s_rd |=> cfg_rdata == p_sh;
  endproperty
  a_rd: assert property (p_rd) else $error("routing readback wrong");
  property p_unm;
    cfg_read && cfg_addr != 8'h8C |=> cfg_rdata == 32'h00000000;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not 0");
  property p_t3;
    sh[15:12] == 4'h1 |=>
      pin_oe[3] && pin_out[3] == $past(serial_interrupt_out);
  endproperty
  a_t3: assert property (p_t3) else $error("serial interrupt route");
  property p_irq6;
    sh[27:24] > 4'h1 |=> pin_oe[6] && pin_out[6] == p_irq[p_sh[27:24]];
  endproperty
  a_irq6: assert property (p_irq6) else $error("terminal 6 irq");
  property p_irq3;
    sh[15:12] > 4'h1 |=> pin_oe[3] && pin_out[3] == p_irq[p_sh[15:12]];
  endproperty
  a_irq3: assert property (p_irq3) else $error("terminal 3 irq");
  property p_rsv;
    sh[27:24] == 4'h0 |=> !pin_oe[6];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code drives");
  property p_gpi;
    sh[3:0] == 4'h0 |=> !pin_oe[0] && general_input[0] == $past(pin_in[0]);
  endproperty
  a_gpi: assert property (p_gpi) else $error("terminal 0 input");
  property p_aud;
    sh[23:20] == 4'h8 |=> pin_oe[5] && pin_out[5] == $past(card_audio_pwm);
  endproperty
  a_aud: assert property (p_aud) else $error("terminal 5 audio");
  property p_ri;
    sh[11:8] == 4'hC |=> pin_oe[2] && pin_out[2] == $past(ring_indicate);
  endproperty
  a_ri: assert property (p_ri) else $error("terminal 2 ring");
  property p_sb;
    !serial_bus_mode_n |=>
      pin_oe[4] == $past(scl_oe) && pin_oe[1] == $past(sda_oe);
  endproperty
  a_sb: assert property (p_sb) else $error("serial bus override");
endmodule // mpr_props
bind mpr_pin_routing mpr_props props (.*);

// ---- verif/mpr_pin_routing_tb_top.sv ----
// self-checking bench for the terminal routing block
`timescale 1ns/1ps
module mpr_pin_routing_tb_top;
  logic        clock, rstn, cfg_write, cfg_read, eeprom_load, sbm_n, sb_oe;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_byte_en;
  logic [31:0] cfg_wdata, eeprom_data, m;
  logic [15:0] irq;
  wire  [31:0] cfg_rdata;
  wire  [6:0]  pin_in, pin_out, pin_oe;
  wire  [4:0]  gpi;
  wire         sda_i, scl_i, clk_i, req_i, lock_i;
  int          miscompares, n_tests;
  mpr_pin_routing dut (.clock(clock), .rstn(rstn), .cfg_write(cfg_write),
    .cfg_read(cfg_read), .cfg_func(m[1]), .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .eeprom_load(eeprom_load), .eeprom_data(eeprom_data),
    .serial_bus_mode_n(sbm_n), .sda_out(m[2]), .sda_oe(sb_oe),
    .scl_out(m[3]), .scl_oe(sb_oe), .sda_in(sda_i), .scl_in(scl_i),
    .irq_lines(irq),
    .serial_interrupt_out(m[4]), .clkrun_out(m[5]), .clkrun_oe(m[6]),
    .clkrun_in(clk_i), .general_output(m[11:7]), .general_input(gpi),
    .inta_out(m[12]), .intb_out(m[13]), .arbitration_grant(m[14]),
    .arbitration_request(req_i), .lock_out(m[15]), .lock_oe(m[16]),
    .lock_in(lock_i),
    .zoom_status(m[17]), .zoom_select_0(m[18]), .zoom_select_1(m[19]),
    .card_audio_pwm(m[20]), .power_state_indicator(m[21]),
    .socket0_activity_led(m[22]), .socket1_activity_led(m[23]),
    .socket_led(m[24]), .general_event(m[25]), .ring_indicate(m[26]),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  mpr_board board (.pin_out(pin_out), .pin_oe(pin_oe), .noise(~m[30:24]),
    .pin_in(pin_in));
  // clock and free-running source pattern
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(negedge clock) m <= m + 32'h00000001;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clock);
    cfg_addr = a;
    cfg_byte_en = be;
    cfg_wdata = d;
    cfg_write = 1'b1;
    @(negedge clock);
    cfg_write = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clock);
    cfg_addr = a;
    cfg_read = 1'b1;
    @(negedge clock);
    cfg_read = 1'b0;
    chk(cfg_rdata, e);
  endtask
  task t_reset;
    @(negedge clock);
    rstn = 1'b0;
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    rd(8'h8C, 32'h00001000);
    chk({25'h0, pin_oe}, 32'h00000008);
  endtask
  task t_access;
    wr(8'h8C, 4'hF, 32'hFFFFFFFF);
    rd(8'h8C, 32'h0FFFFFFF);
    wr(8'h90, 4'hF, 32'h00000000);
    rd(8'h90, 32'h00000000);
    wr(8'h8C, 4'h2, 32'h00002100);
    rd(8'h8C, 32'h0FFF21FF);
  endtask
  // idle terminals read back as inputs; other inputs rest at idle
  task t_inputs;
    logic [6:0] s;
    wr(8'h8C, 4'hF, 32'h00000000);
    repeat (2) @(negedge clock);
    for (int k = 0; k < 4; k++) begin
      @(negedge clock);
      #1 s = pin_in;
      @(negedge clock);
      chk({22'h0, gpi, req_i, lock_i, clk_i, sda_i, scl_i},
          {22'h0, s[5], s[4], s[2], s[1], s[0], 5'h0F});
    end
  endtask
  // every code in every field, interrupt lines in two patterns
  task t_codes;
    logic [3:0] c;
    for (int p = 0; p < 2; p++) for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      irq = p[0] ? 16'hA5C3 : 16'h5A3C;
      wr(8'h8C, 4'hF, {4'h0, {7{c}}});
      rd(8'h8C, {4'h0, {7{c}}});
      if (c == 4'h0)
        chk({30'h0, pin_oe[6], pin_oe[3]}, 32'h00000000);
      else if (c > 4'h1)
        chk({28'h0, pin_oe[6], pin_out[6], pin_oe[3], pin_out[3]},
            {28'h0, 1'b1, irq[c], 1'b1, irq[c]});
    end
  endtask
  // preload beats a config write in the same cycle
  task t_eeprom;
    @(negedge clock);
    eeprom_data = 32'hFFFF5555;
    eeprom_load = 1'b1;
    cfg_addr = 8'h8C;
    cfg_wdata = 32'h00000000;
    cfg_write = 1'b1;
    @(negedge clock);
    eeprom_load = 1'b0;
    cfg_write = 1'b0;
    rd(8'h8C, 32'h0FFF5555);
  endtask
  // strap hands terminals 1 and 4 to the serial-bus engine
  task t_strap;
    wr(8'h8C, 4'hF, 32'h00011010);
    sbm_n = 1'b0;
    sb_oe = 1'b1;
    repeat (2) @(negedge clock);
    chk({30'h0, pin_oe[4], pin_oe[1]}, 32'h00000003);
    sb_oe = 1'b0;
    repeat (2) @(negedge clock);
    chk({30'h0, pin_oe[4], pin_oe[1]}, 32'h00000000);
    sbm_n = 1'b1;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {rstn, cfg_write, cfg_read, eeprom_load, sb_oe} = 5'h00;
    {cfg_addr, cfg_byte_en, cfg_wdata, eeprom_data} = 76'h0;
    m = 32'h00000000;
    irq = 16'h0000;
    sbm_n = 1'b1;
    t_reset();
    t_access();
    t_inputs();
    t_codes();
    t_eeprom();
    t_strap();
    t_reset();
    wrap_up();
  end
  initial begin
    #2000000;
    miscompares++;
    wrap_up();
  end
endmodule // mpr_pin_routing_tb_top
